// [cbt_chk.sv]
// assertion checker for the command bus training block
`timescale 1ns/10ps
`default_nettype none
module cbt_chk (
   input wire logic        core_clk, rst_n, chipSelect, operatingSetpoint,
   input wire logic        trainingActive, readyNormal, modeReadValid,
   input wire logic [5:0]  commandAddress,
   input wire logic [15:0] normDqOe, dqOut, dqOe, dqTerm
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   property p_pwrUp; $rose(rst_n) |-> !operatingSetpoint; endproperty
   a_pwrUp: assert property (p_pwrUp) else $error("set-point after reset");
   property p_swapIn; $rose(trainingActive) |-> $changed(operatingSetpoint); endproperty
   a_swapIn: assert property (p_swapIn) else $error("no swap at entry");
   property p_oeTrain; trainingActive |-> dqOe == 16'h3f00; endproperty
   a_oeTrain: assert property (p_oeTrain) else $error("pin roles in training");
   property p_termOut; trainingActive |-> dqTerm[13:8] == 6'h00; endproperty
   a_termOut: assert property (p_termOut) else $error("output pins terminated");
   // feedback must track a steady selected address within six cycles
   property p_fbMap;
      (trainingActive && chipSelect && $stable(commandAddress)) [*6]
         |-> dqOut[13:8] == commandAddress;
   endproperty
   a_fbMap: assert property (p_fbMap) else $error("feedback mapping");
   property p_swapOut; $fell(trainingActive) |-> $changed(operatingSetpoint); endproperty
   a_swapOut: assert property (p_swapOut) else $error("no swap at exit");
   property p_exitWait; trainingActive || $fell(trainingActive) |-> !readyNormal [*2]; endproperty
   a_exitWait: assert property (p_exitWait) else $error("ready too early");
   property p_normRole;
      !trainingActive && !$past(trainingActive) && $past(rst_n) |-> dqOe == $past(normDqOe);
   endproperty
   a_normRole: assert property (p_normRole) else $error("normal pin roles");
   c_entry: cover property ($rose(trainingActive));
   c_exit: cover property ($fell(trainingActive));
   c_read: cover property (modeReadValid);
endmodule : cbt_chk
bind command_bus_training cbt_chk u_chk (.core_clk(core_clk), .rst_n(rst_n),
   .chipSelect(chipSelect), .operatingSetpoint(operatingSetpoint),
   .trainingActive(trainingActive), .readyNormal(readyNormal), .modeReadValid(modeReadValid),
   .commandAddress(commandAddress), .normDqOe(normDqOe), .dqOut(dqOut), .dqOe(dqOe),
   .dqTerm(dqTerm));
`default_nettype wire

// [cbt_ctrl_model.sv]
// controller-side model presenting reference codes on strobe pair 0
`timescale 1ns/10ps
`default_nettype none
module cbt_ctrl_model (
   input  wire logic        fire,    // rising edge starts one burst
   input  wire logic [6:0]  code,    // code to present
   output logic             strobe,  // stands low between bursts
   output logic      [15:0] dq       // data pins toward the device
);
   initial
   begin
      strobe = 1'b0;
      dq = 16'h0000;
   end
   // three pulses, since the device may miss the first two edges
   always @(posedge fire)
   begin
      dq = {~dq[15:7], code};
      repeat (3)
      begin
         #3 strobe = 1'b1;
         #3 strobe = 1'b0;
      end
      #3 dq[6:0] = ~code;  // released pins do not keep the code
   end
endmodule : cbt_ctrl_model
`default_nettype wire

// [cbt_pkg.sv]
// shared constants and types for the command bus training block
package cbt_pkg;

   // ****************************************************************
   // mode register addresses and field positions
   // ****************************************************************
   localparam logic [5:0] ADDR_CA_REF      = 6'h0c;  // ca_reference_setting
   localparam logic [5:0] ADDR_FREQ_CTRL   = 6'h0d;  // frequency_training_control
   localparam logic [5:0] ADDR_DQ_REF      = 6'h0e;  // dq_reference_setting
   localparam int         TRAIN_EN_BIT     = 0;      // training enable
   localparam int         VRCG_BIT         = 3;      // high current reference mode
   localparam int         WRITE_SETPOINT_SELECT_BIT       = 6;      // write_setpoint_select
   localparam int         OPERATING_SETPOINT_SET_BIT       = 7;      // operating_setpoint_set
   localparam int         CODE_W           = 7;      // range bit plus six value bits
   localparam int         CA_W             = 6;      // command_address_bus width
   localparam int         DQ_W             = 16;     // data pins
   localparam int         FB_LSB           = 8;      // lowest feedback data pin
   localparam int         FB_MSB           = 13;     // highest feedback data pin

   // ****************************************************************
   // reset values
   // ****************************************************************
   localparam logic [7:0] CA_REF_RST       = 8'h00;
   localparam logic [7:0] DQ_REF_RST       = 8'h00;
   localparam logic [7:0] FREQ_CTRL_RST    = 8'h00;  // set-point 0 after power-up

   // ****************************************************************
   // timing: figures in ns, counts derived at the core clock rate
   // ****************************************************************
   localparam int         CLK_MHZ          = 100;
   localparam int         T_MRD_NS         = 14;     // mode_register_delay
   localparam int         T_CAENT_NS       = 250;    // training_entry_delay
   localparam int         T_VREF_LONG_NS   = 250;    // reference_settle_long
   localparam int         T_MRW_NS         = 10;     // mode_write_interval

   // least time: round up, never below one cycle
   function automatic int cyclesMin(input int ns);
      int c;
      c = (ns * CLK_MHZ + 999) / 1000;
      return (c < 1) ? 1 : c;
   endfunction : cyclesMin

   localparam int         MRD_CYC          = cyclesMin(T_MRD_NS);
   localparam int         CAENT_CYC        = cyclesMin(T_CAENT_NS);
   localparam int         VREF_LONG_CYC    = cyclesMin(T_VREF_LONG_NS);
   localparam int         MRW_CYC          = cyclesMin(T_MRW_NS);
   localparam int         TIMER_W          = 8;

   // ****************************************************************
   // training sequencer states
   // ****************************************************************
   typedef enum logic [2:0] {
      ST_NORMAL  = 3'b000,  // ordinary operation
      ST_ARMED   = 3'b001,  // enable written, waiting for clock enable low
      ST_TRAIN   = 3'b010,  // clock enable low, alternate set-point active
      ST_EXITING = 3'b011,  // clock enable high again, enable still set
      ST_RECOVER = 3'b100   // enable cleared, waiting the write interval
   } cbtState_t;

endpackage : cbt_pkg

// [command_bus_training.sv]
// command bus training mode logic of the memory device
//
// Behaviour
// - power-up runs from set-point zero
// - two-part mode write sets training enable
// - clock enable low after delay swaps set-point
// - pins 6..0 take reference code on strobe
// - pin 7 and mask 0 ignored
// - pins 13..8 drive captured address levels
// - strobe 1, mask 1, pins 15..14 undriven
// - after entry delay, codes replace reference
// - pin n maps to reference bit n
// - feedback not aligned to any strobe
// - exit restores previous set-point, then ready
// - trained reference not kept after exit
// - entry from idle or self refresh alike
// - termination follows set-point except outputs
// - pins 13..8 carry address 5..0 in order
`timescale 1ns/10ps
`default_nettype none

module command_bus_training #(
   parameter int MRD_CYC       = cbt_pkg::MRD_CYC,
   parameter int CAENT_CYC     = cbt_pkg::CAENT_CYC,
   parameter int VREF_LONG_CYC = cbt_pkg::VREF_LONG_CYC,
   parameter int MRW_CYC       = cbt_pkg::MRW_CYC
) (
   input  wire logic        core_clk,           // core clock
   input  wire logic        rst_n,              // synchronous reset, active low
   input  wire logic        refStrobe,          // strobe pair 0, link clock
   input  wire logic        clockEnable,        // clock enable pin
   input  wire logic        chipSelect,         // chip select pin
   input  wire logic [5:0]  commandAddress,     // command_address_bus pins
   input  wire logic        modeWriteFirst,     // mode_write_first_part pulse
   input  wire logic        modeWriteSecond,    // mode_write_second_part pulse
   input  wire logic [5:0]  modeAddr,           // mode register address
   input  wire logic [7:0]  modeData,           // mode register operand
   input  wire logic        modeReadReq,        // mode register read pulse
   input  wire logic [5:0]  modeReadAddr,       // mode register read address
   input  wire logic [15:0] dqIn,               // data pin input levels
   input  wire logic [15:0] normDqOut,          // normal data path drive value
   input  wire logic [15:0] normDqOe,           // normal data path drive enable
   input  wire logic [1:0]  termBySet,          // termination enable per set-point
   output logic      [15:0] dqOut,              // data pin drive value
   output logic      [15:0] dqOe,               // data pin drive enable
   output logic      [15:0] dqTerm,             // data pin termination enable
   output logic      [6:0]  caReference,        // effective ca_input_reference code
   output logic      [6:0]  dqReference,        // effective dq reference code
   output logic             operatingSetpoint,  // set-point in use
   output logic             trainingActive,     // training with clock enable low
   output logic             readyNormal,        // normal commands accepted
   output logic      [7:0]  modeReadData,       // mode register read data
   output logic             modeReadValid       // read data valid pulse
);

   // ****************************************************************
   // declarations
   // ****************************************************************
   localparam int TW = cbt_pkg::TIMER_W;

   logic [7:0]                 caRef_r [2];      // ca reference per set-point
   logic [7:0]                 dqRef_r [2];      // dq reference per set-point
   logic [7:0]                 freqCtrl_r;       // frequency and training control
   logic [5:0]                 pendAddr_r;       // first half of a mode write
   logic [7:0]                 pendData_r;
   logic                       pendValid_r;      // first half seen
   cbt_pkg::cbtState_t         state_r;          // sequencer state
   cbt_pkg::cbtState_t         state_nxt;
   logic [TW-1:0]              timer_r;          // shared delay counter
   logic [TW-1:0]              timer_nxt;
   logic [TW-1:0]              settle_r;         // reference settle counter
   logic [6:0]                 trainCode_r;      // reference in force while training
   logic [6:0]                 newCode_r;        // code waiting to settle
   logic                       settling_r;       // settle in progress
   logic [5:0]                 fbCa_r;           // latched address levels
   logic                       ckeSync;          // synchronised pins
   logic                       csSync;
   logic [5:0]                 caSync;
   logic                       ckePrev_r;        // for clock enable edges
   logic                       strobeRstN;       // reset in the strobe domain
   logic [6:0]                 strobeCode_r;     // strobe-domain capture
   logic                       strobeTgl_r;      // flips on each capture
   logic                       tglSync;          // toggle in the core domain
   logic                       tglPrev_r;
   logic                       commitWrite;      // second half completes a write
   logic                       ckeFall;
   logic                       ckeRise;
   logic                       fspOp;
   logic                       fspWr;
   logic                       activeSet;
   logic                       inTrain;
   logic                       acceptCodes;

   // ****************************************************************
   // pin synchronisers
   // ****************************************************************
   // clock enable, select and address levels pass two flops before any logic looks at them
   sync2 #(.W(8)) u_pinSync (
      .clk  (core_clk),
      .rstN (rst_n),
      .d    ({clockEnable, chipSelect, commandAddress}),
      .q    ({ckeSync, csSync, caSync})
   );

   // strobe capture toggle brought into the core domain
   sync2 #(.W(1)) u_tglSync (
      .clk  (core_clk),
      .rstN (rst_n),
      .d    (strobeTgl_r),
      .q    (tglSync)
   );

   // core reset carried into the strobe domain; needs strobe edges to act
   sync2 #(.W(1)) u_strobeRst (
      .clk  (refStrobe),
      .rstN (1'b1),
      .d    (rst_n),
      .q    (strobeRstN)
   );

   // ****************************************************************
   // strobe domain capture
   // ****************************************************************
   // code on pins 6..0 taken on every rising strobe edge; pin 7 and
   // mask 0 are never looked at, so a floating level does no harm
   always_ff @(posedge refStrobe)
   begin
      if (!strobeRstN)
      begin
         strobeCode_r <= '0;
         strobeTgl_r  <= 1'b0;
      end
      else
      begin
         strobeCode_r <= dqIn[cbt_pkg::CODE_W-1:0];
         strobeTgl_r  <= ~strobeTgl_r;
      end
   end

   // ****************************************************************
   // decoding helpers
   // ****************************************************************
   assign fspOp       = freqCtrl_r[cbt_pkg::OPERATING_SETPOINT_SET_BIT];
   assign fspWr       = freqCtrl_r[cbt_pkg::WRITE_SETPOINT_SELECT_BIT];
   assign inTrain     = (state_r == cbt_pkg::ST_TRAIN);
   // alternate set while clock enable is low in training
   assign activeSet   = inTrain ? ~fspOp : fspOp;
   assign commitWrite = modeWriteSecond && pendValid_r;
   assign ckeFall     = ckePrev_r && !ckeSync;
   assign ckeRise     = !ckePrev_r && ckeSync;
   // codes are honoured only once the entry delay has run out
   assign acceptCodes = inTrain && (timer_r == '0);

   // ****************************************************************
   // edge history
   // ****************************************************************
   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         ckePrev_r <= 1'b0;
         tglPrev_r <= 1'b0;
      end
      else
      begin
         ckePrev_r <= ckeSync;
         tglPrev_r <= tglSync;
      end
   end

   // ****************************************************************
   // two-part mode register write
   // ****************************************************************
   // first part holds address and operand; second part commits them
   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         pendAddr_r  <= '0;
         pendData_r  <= '0;
         pendValid_r <= 1'b0;
      end
      else if (modeWriteFirst)
      begin
         pendAddr_r  <= modeAddr;
         pendData_r  <= modeData;
         pendValid_r <= 1'b1;
      end
      else if (modeWriteSecond)
      begin
         pendValid_r <= 1'b0;
      end
   end

   // ****************************************************************
   // mode registers
   // ****************************************************************
   // references land in the set chosen by the write selector; command
   // decoding is off while clock enable is low, so no writes in training
   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         caRef_r[0] <= cbt_pkg::CA_REF_RST;
         caRef_r[1] <= cbt_pkg::CA_REF_RST;
         dqRef_r[0] <= cbt_pkg::DQ_REF_RST;
         dqRef_r[1] <= cbt_pkg::DQ_REF_RST;
         freqCtrl_r <= cbt_pkg::FREQ_CTRL_RST;
      end
      else if (commitWrite && !inTrain)
      begin
         // trained codes never reach these; software rewrites them
         case (pendAddr_r)
            cbt_pkg::ADDR_CA_REF:    caRef_r[fspWr] <= pendData_r;
            cbt_pkg::ADDR_DQ_REF:    dqRef_r[fspWr] <= pendData_r;
            cbt_pkg::ADDR_FREQ_CTRL: freqCtrl_r     <= pendData_r;
            default:                 ;  // unmapped: write dropped
         endcase
      end
   end

   // ****************************************************************
   // training sequencer, next state
   // ****************************************************************
   always_comb
   begin
      state_nxt = state_r;
      timer_nxt = (timer_r != '0) ? timer_r - TW'(1) : timer_r;
      case (state_r)
         cbt_pkg::ST_NORMAL:
         begin
            // clock enable must be high: idle or self refresh alike
            if (commitWrite && !inTrain && ckeSync
                && pendAddr_r == cbt_pkg::ADDR_FREQ_CTRL
                && pendData_r[cbt_pkg::TRAIN_EN_BIT])
            begin
               state_nxt = cbt_pkg::ST_ARMED;
               timer_nxt = TW'(MRD_CYC);
            end
         end
         cbt_pkg::ST_ARMED:
         begin
            if (!freqCtrl_r[cbt_pkg::TRAIN_EN_BIT])
            begin
               state_nxt = cbt_pkg::ST_NORMAL;
            end
            // an early clock enable drop is ignored, not treated as entry
            else if (ckeFall && timer_r == '0)
            begin
               state_nxt = cbt_pkg::ST_TRAIN;
               timer_nxt = TW'(CAENT_CYC);
            end
         end
         cbt_pkg::ST_TRAIN:
         begin
            if (ckeRise)
            begin
               state_nxt = cbt_pkg::ST_EXITING;
            end
         end
         cbt_pkg::ST_EXITING:
         begin
            if (!freqCtrl_r[cbt_pkg::TRAIN_EN_BIT])
            begin
               state_nxt = cbt_pkg::ST_RECOVER;
               timer_nxt = TW'(MRW_CYC);
            end
            // another drop re-enters, as when a second rank is trained
            else if (ckeFall)
            begin
               state_nxt = cbt_pkg::ST_TRAIN;
               timer_nxt = TW'(CAENT_CYC);
            end
         end
         cbt_pkg::ST_RECOVER:
         begin
            if (timer_r == '0)
            begin
               state_nxt = cbt_pkg::ST_NORMAL;
            end
         end
         default:
         begin
            state_nxt = cbt_pkg::ST_NORMAL;
         end
      endcase
   end

   // ****************************************************************
   // training sequencer, state and timer
   // ****************************************************************
   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         state_r <= cbt_pkg::ST_NORMAL;
         timer_r <= '0;
      end
      else
      begin
         state_r <= state_nxt;
         timer_r <= timer_nxt;
      end
   end

   // ****************************************************************
   // reference code update during training
   // ****************************************************************
   // a fresh code waits the long settle time before it takes effect;
   // the strobe register is read only after its toggle crossed, and the
   // controller repeats each code, so a later edge rewrites the same value
   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         trainCode_r <= '0;
         newCode_r   <= '0;
         settling_r  <= 1'b0;
         settle_r    <= '0;
      end
      else if (!inTrain)
      begin
         // preload from the alternate set; dropped again at exit
         trainCode_r <= caRef_r[~fspOp][cbt_pkg::CODE_W-1:0];
         settling_r  <= 1'b0;
         settle_r    <= '0;
      end
      else if (acceptCodes && (tglSync != tglPrev_r))
      begin
         newCode_r  <= strobeCode_r;
         settling_r <= 1'b1;
         settle_r   <= TW'(VREF_LONG_CYC);
      end
      else if (settling_r)
      begin
         if (settle_r == TW'(1))
         begin
            trainCode_r <= newCode_r;
            settling_r  <= 1'b0;
         end
         settle_r <= settle_r - TW'(1);
      end
   end

   // ****************************************************************
   // command/address feedback latch
   // ****************************************************************
   // levels taken in training whenever select is high, free of any strobe timing
   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         fbCa_r <= '0;
      end
      else if (inTrain && csSync)
      begin
         fbCa_r <= caSync;
      end
   end

   // ****************************************************************
   // data pin roles and termination
   // ****************************************************************
   // training: pins 13..8 drive, all others (15..14 included) float
   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         dqOut  <= '0;
         dqOe   <= '0;
         dqTerm <= '0;
      end
      else if (inTrain)
      begin
         dqOut                                  <= '0;
         dqOut[cbt_pkg::FB_MSB:cbt_pkg::FB_LSB] <= fbCa_r;
         dqOe                                   <= '0;
         dqOe[cbt_pkg::FB_MSB:cbt_pkg::FB_LSB]  <= '1;
         // outputs never terminate, inputs follow the active set
         dqTerm <= {cbt_pkg::DQ_W{termBySet[activeSet]}}
                   & ~(16'h3f00);
      end
      else
      begin
         dqOut  <= normDqOut;
         dqOe   <= normDqOe;
         dqTerm <= {cbt_pkg::DQ_W{termBySet[activeSet]}} & ~normDqOe;
      end
   end

   // ****************************************************************
   // mode register read
   // ****************************************************************
   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         modeReadData  <= '0;
         modeReadValid <= 1'b0;
      end
      else
      begin
         modeReadValid <= modeReadReq;
         if (modeReadReq)
         begin
            case (modeReadAddr)
               cbt_pkg::ADDR_CA_REF:    modeReadData <= caRef_r[fspWr];
               cbt_pkg::ADDR_DQ_REF:    modeReadData <= dqRef_r[fspWr];
               cbt_pkg::ADDR_FREQ_CTRL: modeReadData <= freqCtrl_r;
               default:                 modeReadData <= '0;
            endcase
         end
      end
   end

   // ****************************************************************
   // status and reference outputs
   // ****************************************************************
   // registered so the analog side never sees a decode glitch
   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         caReference       <= '0;
         dqReference       <= '0;
         operatingSetpoint <= 1'b0;
         trainingActive    <= 1'b0;
         readyNormal       <= 1'b0;
      end
      else
      begin
         caReference       <= inTrain ? trainCode_r
                              : caRef_r[activeSet][cbt_pkg::CODE_W-1:0];
         dqReference       <= dqRef_r[activeSet][cbt_pkg::CODE_W-1:0];
         operatingSetpoint <= activeSet;
         trainingActive    <= inTrain;
         readyNormal       <= (state_r == cbt_pkg::ST_NORMAL);
      end
   end

endmodule : command_bus_training

`default_nettype wire

// [sync2.sv]
// two flip-flop synchroniser for levels entering a clock domain
`timescale 1ns/10ps
`default_nettype none

module sync2 #(
   parameter int W = 1
) (
   input  wire logic          clk,
   input  wire logic          rstN,
   input  wire logic [W-1:0]  d,
   output logic      [W-1:0]  q
);

   // ****************************************************************
   // synchroniser stages
   // ****************************************************************
   logic [W-1:0] meta_r;  // first stage, read only by the second

   // first stage feeds nothing but q
   always_ff @(posedge clk)
   begin
      if (!rstN)
      begin
         meta_r <= '0;
         q      <= '0;
      end
      else
      begin
         meta_r <= d;
         q      <= meta_r;
      end
   end

endmodule : sync2

`default_nettype wire

// [tb_command_bus_training.sv]
// self-checking bench for the command bus training block
`timescale 1ns/10ps
`default_nettype none
module tb_command_bus_training;
   logic core_clk = 0, rst_n = 0, clockEnable = 1, chipSelect = 0, fire = 0;
   logic modeWriteFirst = 0, modeWriteSecond = 0, modeReadReq = 0, refStrobe;
   logic [5:0] commandAddress = 0, modeAddr = 0, modeReadAddr = 0;
   logic [7:0] modeData = 0, modeReadData;
   logic [6:0] code = 0, caReference, dqReference;
   logic [15:0] dqIn, dqOut, dqOe, dqTerm;
   logic operatingSetpoint, trainingActive, readyNormal, modeReadValid;
   logic [5:0] pat [4] = '{6'h2a, 6'h15, 6'h3f, 6'h01};
   logic [6:0] cds [2] = '{7'h4b, 7'h34};
   int n_errors = 0, checks_done = 0, i;
   command_bus_training dut (.core_clk(core_clk), .rst_n(rst_n), .refStrobe(refStrobe),
      .clockEnable(clockEnable), .chipSelect(chipSelect), .commandAddress(commandAddress),
      .modeWriteFirst(modeWriteFirst), .modeWriteSecond(modeWriteSecond), .modeAddr(modeAddr),
      .modeData(modeData), .modeReadReq(modeReadReq), .modeReadAddr(modeReadAddr),
      .dqIn(dqIn), .normDqOut(16'h5a5a), .normDqOe(16'h00ff), .termBySet(2'b10),
      .dqOut(dqOut), .dqOe(dqOe), .dqTerm(dqTerm), .caReference(caReference),
      .dqReference(dqReference), .operatingSetpoint(operatingSetpoint),
      .trainingActive(trainingActive), .readyNormal(readyNormal),
      .modeReadData(modeReadData), .modeReadValid(modeReadValid));
   cbt_ctrl_model far (.fire(fire), .code(code), .strobe(refStrobe), .dq(dqIn));
   initial forever #5 core_clk = ~core_clk;
   task automatic chk(input string what, input logic [15:0] seen, exp);
      checks_done++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   // two-part mode write, parts back to back
   task automatic mw(input logic [5:0] a, input logic [7:0] d);
      @(negedge core_clk);
      {modeWriteFirst, modeAddr, modeData} = {1'b1, a, d};
      @(negedge core_clk);
      {modeWriteFirst, modeWriteSecond} = 2'b01;
      @(negedge core_clk);
      modeWriteSecond = 1'b0;
   endtask : mw
   task automatic mr(input logic [5:0] a, input logic [7:0] exp);
      @(negedge core_clk);
      {modeReadReq, modeReadAddr} = {1'b1, a};
      @(negedge core_clk);
      modeReadReq = 1'b0;
      chk("read valid", modeReadValid, 1'b1);
      chk("read data", modeReadData, exp);
   endtask : mr
   task automatic close_out;
      $display("checks %0d mismatches %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : close_out
   initial
   begin
      #30000 n_errors++;
      close_out();
   end
   initial
   begin
      @(negedge core_clk);
      fire = 1;  // strobe pulses clear the capture domain in reset
      repeat (3) @(negedge core_clk);
      rst_n = 1;
      chk("set-point", operatingSetpoint, 1'b0);
      mr(cbt_pkg::ADDR_FREQ_CTRL, cbt_pkg::FREQ_CTRL_RST);
      mw(cbt_pkg::ADDR_FREQ_CTRL, 8'h40);
      mw(cbt_pkg::ADDR_CA_REF, 8'h15);
      mw(cbt_pkg::ADDR_DQ_REF, 8'h2a);
      mr(cbt_pkg::ADDR_CA_REF, 8'h15);
      mw(cbt_pkg::ADDR_FREQ_CTRL, 8'h41);
      repeat (3) @(negedge core_clk);
      clockEnable = 0;
      for (i = 0; i < 10 && trainingActive !== 1'b1; i++) @(negedge core_clk);
      chk("set-point", operatingSetpoint, 1'b1);
      chk("ca ref", caReference, 7'h15);
      chk("dq ref", dqReference, 7'h2a);
      chk("drive", dqOe, 16'h3f00);
      chk("term", dqTerm[6:0], 7'h7f);
      {fire, code} = {1'b0, 7'h22};
      @(negedge core_clk);
      fire = 1;  // too early: inside the entry delay
      chipSelect = 1;
      foreach (pat[k])
      begin
         commandAddress = pat[k];
         repeat (8) @(negedge core_clk);
         chk("feedback", dqOut[13:8], pat[k]);
      end
      {chipSelect, commandAddress} = {1'b0, 6'h0c};
      repeat (8) @(negedge core_clk);
      chk("held", dqOut[13:8], 6'h01);
      chk("ca ref", caReference, 7'h15);
      foreach (cds[k])
      begin
         {fire, code} = {1'b0, cds[k]};
         @(negedge core_clk);
         fire = 1;
         repeat (40) @(negedge core_clk);
         chk("ca ref", caReference, cds[k]);
      end
      clockEnable = 1;
      for (i = 0; i < 10 && trainingActive !== 1'b0; i++) @(negedge core_clk);
      chk("set-point", operatingSetpoint, 1'b0);
      @(negedge core_clk);
      chk("drive", dqOe, 16'h00ff);
      repeat (25) @(negedge core_clk);
      mw(cbt_pkg::ADDR_FREQ_CTRL, 8'h40);
      for (i = 0; i < 10 && readyNormal !== 1'b1; i++) @(negedge core_clk);
      chk("ready", readyNormal, 1'b1);
      mr(cbt_pkg::ADDR_CA_REF, 8'h15);
      chk("ca ref", caReference, 7'h00);
      close_out();
   end
endmodule : tb_command_bus_training
`default_nettype wire
